// >>> core/evt_pkg.sv
// shared types, constants and decode functions for the event entry unit
package evt_pkg;

    localparam logic [31:0] RESET_ADDR = 32'h8000_0000;
    localparam int NCAUSE = 8;
    localparam int CW = 3;
    localparam int IRQ_OFF_W = 14;

    // cause bit positions; lower position means higher priority
    localparam logic [CW-1:0] C_BUSERR = 3'h0;
    localparam logic [CW-1:0] C_TLBMISS = 3'h1;
    localparam logic [CW-1:0] C_ADDRERR = 3'h2;
    localparam logic [CW-1:0] C_PRIV = 3'h3;
    localparam logic [CW-1:0] C_ILLEGAL = 3'h4;
    localparam logic [CW-1:0] C_SCALL = 3'h5;
    localparam logic [CW-1:0] C_RETS = 3'h6;
    localparam logic [CW-1:0] C_RETD = 3'h7;

    // handler offsets from the event vector base
    localparam logic [31:0] OFF_BUSERR = 32'h0000_0008;
    localparam logic [31:0] OFF_ADDRERR = 32'h0000_0010;
    localparam logic [31:0] OFF_ILLEGAL = 32'h0000_0014;
    localparam logic [31:0] OFF_PRIV = 32'h0000_0018;
    localparam logic [31:0] OFF_DEBUG = 32'h0000_001C;
    localparam logic [31:0] OFF_TLBMISS = 32'h0000_0050;
    localparam logic [31:0] OFF_SCALL = 32'h0000_0100;
    localparam logic [31:0] VECBASE_RESET = 32'h0000_0000;

    localparam logic [2:0] MODE_USER = 3'h0;
    localparam logic [2:0] MODE_SUPV = 3'h1;
    localparam logic [2:0] MODE_EXC = 3'h6;

    typedef struct packed {
        logic debug_mask_bit;
        logic debug_state_flag;
        logic globalMask;
        logic [2:0] mode;
    } sr_t;

    localparam sr_t SR_RESET = '{1'b0, 1'b0, 1'b1, MODE_SUPV};

    typedef struct packed {
        logic valid;
        logic [NCAUSE-1:0] cause;
        logic [31:0] retPc;
    } stage_evt_t;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_RUN = 3'b010,
        ST_POP = 3'b100
    } state_t;

    // fixed priority: lowest set position wins
    function automatic logic [CW-1:0] pickCause(input logic [NCAUSE-1:0] c);
        logic [CW-1:0] idx;
        idx = '0;
        for (int i = NCAUSE - 1; i >= 0; i--)
        begin
            if (c[i])
                idx = CW'(i);
        end
        return idx;
    endfunction

    // every vectored cause has its own entry point, except that C_PRIV and the default (C_RETS, C_RETD) share OFF_PRIV
    function automatic logic [31:0] causeOffset(input logic [CW-1:0] c);
        logic [31:0] off;
        off = OFF_PRIV;
        case (c)
            C_BUSERR: off = OFF_BUSERR;
            C_TLBMISS: off = OFF_TLBMISS;
            C_ADDRERR: off = OFF_ADDRERR;
            C_ILLEGAL: off = OFF_ILLEGAL;
            C_SCALL: off = OFF_SCALL;
            default: off = OFF_PRIV;
        endcase
        return off;
    endfunction

endpackage

// >>> core/event_pick.sv
// oldest-stage, highest-priority event selector
`timescale 1ns/1ps
module event_pick
    import evt_pkg::*;
#(
    parameter int NSTAGE = 3
)
(
    input stage_evt_t [NSTAGE-1:0] stages,
    output logic hit,
    output logic [$clog2(NSTAGE)-1:0] stageIdx,
    output logic [CW-1:0] causeIdx
);

    // index NSTAGE-1 is the oldest; scanning upward lets it override
    always_comb
    begin
        hit = 1'b0;
        stageIdx = '0;
        causeIdx = '0;
        for (int s = 0; s < NSTAGE; s++)
        begin
            if (stages[s].valid && (|stages[s].cause))
            begin
                hit = 1'b1;
                stageIdx = ($clog2(NSTAGE))'(s);
                causeIdx = pickCause(stages[s].cause);
            end
        end
    end

endmodule

// >>> core/debug_ctx.sv
// dedicated return address and return status for debug mode
`timescale 1ns/1ps
module debug_ctx
    import evt_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic save,
    input wire logic [31:0] saveAddr,
    input sr_t saveSr,
    output logic [31:0] retAddr_r,
    output sr_t retSr_r
);

    logic [31:0] retAddr_nxt;
    sr_t retSr_nxt;

    // kept apart from the system stack so debug entry and exit never push or pop it
    always_comb
    begin
        retAddr_nxt = retAddr_r;
        retSr_nxt = retSr_r;
        if (save)
        begin
            retAddr_nxt = saveAddr;
            retSr_nxt = saveSr;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            retAddr_r <= RESET_ADDR;
            retSr_r <= SR_RESET;
        end
        else
        begin
            retAddr_r <= retAddr_nxt;
            retSr_r <= retSr_nxt;
        end
    end

endmodule

// >>> core/cpu_event_entry_debug.sv
// event dispatch, supervisor call/return and debug entry/exit of the core
`timescale 1ns/1ps
module cpu_event_entry_debug
    import evt_pkg::*;
#(
    parameter int NSTAGE = 3
)
(
    input wire logic clk,
    input wire logic rstn,
    input stage_evt_t [NSTAGE-1:0] stages,
    input wire logic dbgReq,
    input wire logic [31:0] resumePc,
    input wire logic irqReq,
    input wire logic [IRQ_OFF_W-1:0] irqOffset,
    input wire logic vecBaseWrEn,
    input wire logic [31:0] vecBaseWrData,
    input wire logic srWrEn,
    input sr_t srWrData,
    input wire logic popValid,
    input wire logic [31:0] popPc,
    input sr_t popSr,
    output logic redirValid_r,
    output logic [31:0] redirPc_r,
    output logic [NSTAGE-1:0] stageAck_r,
    output logic irqAck_r,
    output logic pushValid_r,
    output logic [31:0] pushPc_r,
    output sr_t pushSr_r,
    output logic popReq,
    output logic busy,
    output logic privileged,
    output sr_t sr_r,
    output logic [31:0] vecBase_r,
    output logic [31:0] dbgRetAddr,
    output sr_t dbgRetSr
);

    localparam int SW = $clog2(NSTAGE);

    state_t state_r;
    state_t state_nxt;
    sr_t sr_nxt;
    logic [31:0] vecBase_nxt;
    logic redirValid_nxt;
    logic [31:0] redirPc_nxt;
    logic [NSTAGE-1:0] stageAck_nxt;
    logic irqAck_nxt;
    logic pushValid_nxt;
    logic [31:0] pushPc_nxt;
    sr_t pushSr_nxt;
    logic pickHit;
    logic [SW-1:0] pickStage;
    logic [CW-1:0] pickIdx;
    logic dbgSave;
    logic dbgTake;
    logic irqTake;
    logic [31:0] pickRetPc;

    event_pick #(
        .NSTAGE(NSTAGE)
    ) event_pick_i (
        .stages(stages),
        .hit(pickHit),
        .stageIdx(pickStage),
        .causeIdx(pickIdx)
    );

    debug_ctx debug_ctx_i (
        .clk(clk),
        .rstn(rstn),
        .save(dbgSave),
        .saveAddr(resumePc),
        .saveSr(sr_r),
        .retAddr_r(dbgRetAddr),
        .retSr_r(dbgRetSr)
    );

    assign pickRetPc = stages[pickStage].retPc;
    assign popReq = (state_r == ST_POP);
    assign busy = (state_r != ST_RUN);
    // debug state always carries full privilege
    assign privileged = sr_r.debug_state_flag || (sr_r.mode != MODE_USER);
    // a pending debug entry is held off by the mask or by being in debug already
    assign dbgTake = dbgReq && !sr_r.debug_mask_bit && !sr_r.debug_state_flag;
    assign irqTake = irqReq && !sr_r.globalMask && !sr_r.debug_state_flag;

    always_comb
    begin
        state_nxt = state_r;
        sr_nxt = sr_r;
        // dispatch below reads vecBase_r, so a write lands only for later events
        vecBase_nxt = vecBaseWrEn ? vecBaseWrData : vecBase_r;
        redirValid_nxt = 1'b0;
        redirPc_nxt = redirPc_r;
        stageAck_nxt = '0;
        irqAck_nxt = 1'b0;
        pushValid_nxt = 1'b0;
        pushPc_nxt = pushPc_r;
        pushSr_nxt = pushSr_r;
        dbgSave = 1'b0;
        // software status write; mode is free in debug since privileged is high
        if (srWrEn && privileged)
        begin
            sr_nxt.debug_mask_bit = srWrData.debug_mask_bit;
            sr_nxt.globalMask = srWrData.globalMask;
            sr_nxt.mode = srWrData.mode;
        end
        case (state_r)
            ST_BOOT:
            begin
                redirValid_nxt = 1'b1;
                redirPc_nxt = RESET_ADDR;
                state_nxt = ST_RUN;
            end
            ST_RUN:
            begin
                // pipeline events outrank asynchronous requests
                if (pickHit)
                begin
                    stageAck_nxt[pickStage] = 1'b1;
                    case (pickIdx)
                        C_RETD:
                        begin
                            if (sr_r.debug_state_flag)
                            begin
                                sr_nxt = dbgRetSr;
                                redirValid_nxt = 1'b1;
                                redirPc_nxt = dbgRetAddr;
                            end
                            else
                            begin
                                sr_nxt.mode = MODE_EXC;
                                redirValid_nxt = 1'b1;
                                redirPc_nxt = vecBase_r + OFF_PRIV;
                            end
                        end
                        C_RETS:
                        begin
                            state_nxt = ST_POP;
                        end
                        C_SCALL:
                        begin
                            pushValid_nxt = 1'b1;
                            pushPc_nxt = pickRetPc;
                            pushSr_nxt = sr_r;
                            sr_nxt.mode = MODE_SUPV;
                            redirValid_nxt = 1'b1;
                            redirPc_nxt = vecBase_r + causeOffset(pickIdx);
                        end
                        default:
                        begin
                            sr_nxt.mode = MODE_EXC;
                            redirValid_nxt = 1'b1;
                            redirPc_nxt = vecBase_r + causeOffset(pickIdx);
                        end
                    endcase
                end
                else if (dbgTake)
                begin
                    // return context goes to dedicated registers, not the stack
                    dbgSave = 1'b1;
                    sr_nxt.debug_state_flag = 1'b1;
                    sr_nxt.mode = MODE_EXC;
                    redirValid_nxt = 1'b1;
                    redirPc_nxt = vecBase_r + OFF_DEBUG;
                end
                else if (irqTake)
                begin
                    irqAck_nxt = 1'b1;
                    sr_nxt.globalMask = 1'b1;
                    redirValid_nxt = 1'b1;
                    redirPc_nxt = vecBase_r + {{(32 - IRQ_OFF_W){1'b0}}, irqOffset};
                end
            end
            ST_POP:
            begin
                // resume the caller's context; debug state itself is not restored from the stack
                if (popValid)
                begin
                    sr_nxt = popSr;
                    sr_nxt.debug_state_flag = sr_r.debug_state_flag;
                    redirValid_nxt = 1'b1;
                    redirPc_nxt = popPc;
                    state_nxt = ST_RUN;
                end
            end
            default:
            begin
                state_nxt = ST_BOOT;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_r <= ST_BOOT;
            sr_r <= SR_RESET;
            vecBase_r <= VECBASE_RESET;
            redirValid_r <= 1'b0;
            redirPc_r <= RESET_ADDR;
            stageAck_r <= '0;
            irqAck_r <= 1'b0;
            pushValid_r <= 1'b0;
            pushPc_r <= 32'h0000_0000;
            pushSr_r <= SR_RESET;
        end
        else
        begin
            state_r <= state_nxt;
            sr_r <= sr_nxt;
            vecBase_r <= vecBase_nxt;
            redirValid_r <= redirValid_nxt;
            redirPc_r <= redirPc_nxt;
            stageAck_r <= stageAck_nxt;
            irqAck_r <= irqAck_nxt;
            pushValid_r <= pushValid_nxt;
            pushPc_r <= pushPc_nxt;
            pushSr_r <= pushSr_nxt;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    logic anyPend;
    assign anyPend = pickHit;

    dbg_enter_a: assert property (
        state_r == ST_RUN && dbgReq && !sr_r.debug_mask_bit && !sr_r.debug_state_flag
        && !anyPend |=> sr_r.debug_state_flag && redirValid_r)
        else $error("unmasked debug request was not taken");

    dbg_mask_a: assert property (
        $rose(sr_r.debug_state_flag) |-> !$past(sr_r.debug_mask_bit))
        else $error("debug entered while masked");

    dbg_vector_a: assert property (
        $rose(sr_r.debug_state_flag) |-> redirValid_r
        && redirPc_r == $past(vecBase_r) + OFF_DEBUG)
        else $error("debug entry did not jump to debug handler");

    dbg_ctx_a: assert property (
        $rose(sr_r.debug_state_flag) |-> dbgRetAddr == $past(resumePc)
        && dbgRetSr == $past(sr_r) && !pushValid_r && sr_r.mode == MODE_EXC)
        else $error("debug context not saved in dedicated registers");

    dbg_priv_a: assert property (
        sr_r.debug_state_flag && srWrEn |=> privileged && sr_r.mode == $past(srWrData.mode)
        || redirValid_r)
        else $error("mode write refused in debug mode");

    dbg_exit_a: assert property (
        $fell(sr_r.debug_state_flag) |-> redirValid_r && redirPc_r == $past(dbgRetAddr)
        && sr_r == $past(dbgRetSr))
        else $error("debug return did not restore context");

    reset_fetch_a: assert property (
        $past(!rstn) && rstn |=> redirValid_r && redirPc_r == RESET_ADDR)
        else $error("first fetch not at reset address");

    tlb_vector_a: assert property (
        state_r == ST_RUN && pickHit && pickIdx == C_TLBMISS
        |=> redirValid_r && redirPc_r == $past(vecBase_r) + OFF_TLBMISS)
        else $error("translation miss vectored wrongly");

    irq_vector_a: assert property (
        irqAck_r |-> redirValid_r && redirPc_r == $past(vecBase_r)
        + {{(32 - IRQ_OFF_W){1'b0}}, $past(irqOffset)})
        else $error("interrupt target is not base plus offset");

    oldest_first_a: assert property (
        state_r == ST_RUN && stages[NSTAGE-1].valid && (|stages[NSTAGE-1].cause)
        |=> stageAck_r[NSTAGE-1] && !irqAck_r)
        else $error("older instruction was not handled first");

    prio_pick_a: assert property (
        state_r == ST_RUN && pickHit && pickIdx == C_ILLEGAL
        |-> !stages[pickStage].cause[C_BUSERR] && !stages[pickStage].cause[C_PRIV])
        else $error("lower priority cause chosen");

    scall_push_a: assert property (
        pushValid_r |-> pushSr_r == $past(sr_r) && sr_r.mode == MODE_SUPV
        && redirPc_r == $past(vecBase_r) + OFF_SCALL)
        else $error("supervisor call did not push context");

    rets_pop_a: assert property (
        state_r == ST_POP && popValid |=> state_r == ST_RUN && redirPc_r == $past(popPc)
        && sr_r.mode == $past(popSr.mode))
        else $error("supervisor return did not resume caller");

    base_late_a: assert property (
        vecBaseWrEn && irqTake && state_r == ST_RUN && !pickHit && !dbgTake
        |=> redirPc_r == $past(vecBase_r) + {{(32 - IRQ_OFF_W){1'b0}}, $past(irqOffset)})
        else $error("base write leaked into dispatch in flight");

    dbg_cover_c: cover property ($rose(sr_r.debug_state_flag) ##[1:20] $fell(sr_r.debug_state_flag));
    irq_cover_c: cover property (irqAck_r);
    scall_cover_c: cover property (pushValid_r ##[1:50] (state_r == ST_POP && popValid));

endmodule

// >>> dv/stack_model.sv
// behavioural system stack that answers the core's push and pop requests
`timescale 1ns/1ps
module stack_model
    import evt_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] popDelay,
    input wire logic pushValid_r,
    input wire logic [31:0] pushPc_r,
    input sr_t pushSr_r,
    input wire logic popReq,
    output logic popValid,
    output logic [31:0] popPc,
    output sr_t popSr
);
    logic [31:0] pcMem[$];
    sr_t srMem[$];
    logic [3:0] waitCnt;

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            pcMem.delete();
            srMem.delete();
            popValid <= 1'b0;
            waitCnt <= 4'h0;
            popPc <= 32'h5555_5555;
            popSr <= '0;
        end
        else
        begin
            popValid <= 1'b0;
            // data is not held after the pulse, so a late sample sees garbage
            popPc <= ~popPc;
            popSr <= ~popSr;
            if (pushValid_r)
            begin
                pcMem.push_back(pushPc_r);
                srMem.push_back(pushSr_r);
            end
            if (popReq && !popValid)
            begin
                if (waitCnt == popDelay)
                begin
                    waitCnt <= 4'h0;
                    popValid <= 1'b1;
                    // empty stack keeps the inverted junk value
                    if (pcMem.size() > 0)
                    begin
                        popPc <= pcMem.pop_back();
                        popSr <= srMem.pop_back();
                    end
                end
                else
                    waitCnt <= waitCnt + 4'h1;
            end
        end
    end
endmodule

// >>> dv/cpu_event_entry_debug_tb_top.sv
// self-checking testbench for the event entry and debug unit
`timescale 1ns/1ps
module cpu_event_entry_debug_tb_top
    import evt_pkg::*;
;
    localparam logic [31:0] BASE = 32'h0000_4000;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    stage_evt_t [2:0] stages = '0;
    logic dbgReq = 1'b0, irqReq = 1'b0, vecBaseWrEn = 1'b0, srWrEn = 1'b0;
    logic [31:0] resumePc = 32'h0000_0000, vecBaseWrData = 32'h0000_0000;
    logic [IRQ_OFF_W-1:0] irqOffset = 14'h0000;
    sr_t srWrData = '0;
    logic [3:0] popDelay = 4'h0;
    logic popValid, popReq, busy, privileged, redirValid_r, irqAck_r, pushValid_r;
    logic [31:0] popPc, redirPc_r, pushPc_r, vecBase_r, dbgRetAddr;
    sr_t popSr, pushSr_r, sr_r, dbgRetSr;
    logic [2:0] stageAck_r;
    int badCount = 0, testsRun = 0, cycles = 0;
    logic [7:0] bitTab[6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h80};
    logic [31:0] offTab[6] = '{OFF_BUSERR, OFF_TLBMISS, OFF_ADDRERR, OFF_PRIV,
        OFF_ILLEGAL, OFF_PRIV};

    always #5 clk = ~clk;

    cpu_event_entry_debug #(.NSTAGE(3)) cpu_event_entry_debug_i (.clk(clk), .rstn(rstn),
        .stages(stages), .dbgReq(dbgReq), .resumePc(resumePc), .irqReq(irqReq),
        .irqOffset(irqOffset), .vecBaseWrEn(vecBaseWrEn), .vecBaseWrData(vecBaseWrData),
        .srWrEn(srWrEn), .srWrData(srWrData), .popValid(popValid), .popPc(popPc),
        .popSr(popSr), .redirValid_r(redirValid_r), .redirPc_r(redirPc_r),
        .stageAck_r(stageAck_r), .irqAck_r(irqAck_r), .pushValid_r(pushValid_r),
        .pushPc_r(pushPc_r), .pushSr_r(pushSr_r), .popReq(popReq), .busy(busy),
        .privileged(privileged), .sr_r(sr_r), .vecBase_r(vecBase_r),
        .dbgRetAddr(dbgRetAddr), .dbgRetSr(dbgRetSr));

    stack_model stack_model_i (.clk(clk), .rstn(rstn), .popDelay(popDelay),
        .pushValid_r(pushValid_r), .pushPc_r(pushPc_r), .pushSr_r(pushSr_r),
        .popReq(popReq), .popValid(popValid), .popPc(popPc), .popSr(popSr));

    task automatic finishTest;
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp)
        begin
            badCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkSr(input string what, input sr_t exp, input sr_t got);
        testsRun++;
        if (got !== exp)
        begin
            badCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // all tasks start and end at a falling edge, except finishTest when the timeout calls it at a rising edge
    task automatic clearIns;
        stages = '0;
        dbgReq = 1'b0;
        irqReq = 1'b0;
        vecBaseWrEn = 1'b0;
        srWrEn = 1'b0;
    endtask

    task automatic raise(input int s, input logic [7:0] c, input logic [31:0] pc);
        stages[s] = '{1'b1, c, pc};
        @(negedge clk);
        clearIns();
    endtask

    task automatic writeSr(input sr_t v);
        srWrEn = 1'b1;
        srWrData = v;
        @(negedge clk);
        srWrEn = 1'b0;
    endtask

    task automatic doRets(input logic [3:0] dly, input logic [31:0] pc, input sr_t sr);
        popDelay = dly;
        raise(2, 8'h40, 32'h0000_0000);
        chk32("pop request", 32'h1, 32'(popReq));
        chk32("busy in pop", 32'h1, 32'(busy));
        for (int n = 0; n < 20 && redirValid_r !== 1'b1; n++)
            @(negedge clk);
        chk32("return pc", pc, redirPc_r);
        chkSr("return status", sr, sr_r);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            badCount++;
            finishTest();
        end
    end

    initial
    begin
        repeat (12) @(negedge clk);
        chk32("reset pc", RESET_ADDR, redirPc_r);
        chk32("busy in reset", 32'h1, 32'(busy));
        rstn = 1'b1;
        @(negedge clk);
        chk32("boot redirect", 32'h1, 32'(redirValid_r));
        chk32("boot pc", RESET_ADDR, redirPc_r);
        @(negedge clk);
        // base written on the same edge as an event: old base still used
        vecBaseWrEn = 1'b1;
        vecBaseWrData = BASE;
        raise(2, 8'h01, 32'h0000_1000);
        chk32("old base", VECBASE_RESET + OFF_BUSERR, redirPc_r);
        chk32("base reg", BASE, vecBase_r);
        for (int i = 0; i < 6; i++)
        begin
            raise(2, bitTab[i], 32'h0000_1000);
            chk32("vector", BASE + offTab[i], redirPc_r);
        end
        raise(2, 8'h1C, 32'h0000_1000);
        chk32("same insn priority", BASE + OFF_ADDRERR, redirPc_r);
        raise(2, 8'h30, 32'h0000_1000);
        chk32("illegal over call", BASE + OFF_ILLEGAL, redirPc_r);
        chk32("no push", 32'h0, 32'(pushValid_r));
        stages[0] = '{1'b1, 8'h01, 32'h0000_1004};
        raise(2, 8'h10, 32'h0000_1000);
        chk32("oldest ack", 32'h4, 32'(stageAck_r));
        chk32("oldest pc", BASE + OFF_ILLEGAL, redirPc_r);
        stages[0] = '{1'b1, 8'h01, 32'h0000_1004};
        raise(1, 8'h10, 32'h0000_1000);
        chk32("middle ack", 32'h2, 32'(stageAck_r));
        writeSr('{1'b1, 1'b0, 1'b1, MODE_SUPV});
        dbgReq = 1'b1;
        resumePc = 32'h0000_2468;
        repeat (4)
        begin
            @(negedge clk);
            chk32("masked debug", 32'h0, 32'(redirValid_r));
        end
        chk32("no debug flag", 32'h0, 32'(sr_r.debug_state_flag));
        dbgReq = 1'b0;
        writeSr('{1'b0, 1'b0, 1'b1, MODE_SUPV});
        dbgReq = 1'b1;
        @(negedge clk);
        clearIns();
        chk32("debug pc", BASE + OFF_DEBUG, redirPc_r);
        chk32("debug flag", 32'h1, 32'(sr_r.debug_state_flag));
        chk32("debug mode", 32'(MODE_EXC), 32'(sr_r.mode));
        chk32("debug ret addr", 32'h0000_2468, dbgRetAddr);
        chkSr("debug ret sr", '{1'b0, 1'b0, 1'b1, MODE_SUPV}, dbgRetSr);
        chk32("debug no push", 32'h0, 32'(pushValid_r));
        writeSr('{1'b0, 1'b0, 1'b1, MODE_USER});
        chk32("debug mode write", 32'(MODE_USER), 32'(sr_r.mode));
        chk32("debug privilege", 32'h1, 32'(privileged));
        raise(2, 8'h80, 32'h0000_1000);
        chk32("debug return pc", 32'h0000_2468, redirPc_r);
        chkSr("debug return sr", '{1'b0, 1'b0, 1'b1, MODE_SUPV}, sr_r);
        writeSr('{1'b0, 1'b0, 1'b0, MODE_USER});
        raise(2, 8'h20, 32'h0000_3000);
        chk32("push pulse", 32'h1, 32'(pushValid_r));
        chk32("push pc", 32'h0000_3000, pushPc_r);
        chkSr("push sr", '{1'b0, 1'b0, 1'b0, MODE_USER}, pushSr_r);
        chk32("call pc", BASE + OFF_SCALL, redirPc_r);
        chk32("call mode", 32'(MODE_SUPV), 32'(sr_r.mode));
        raise(2, 8'h20, 32'h0000_3100);
        doRets(4'h0, 32'h0000_3100, '{1'b0, 1'b0, 1'b0, MODE_SUPV});
        doRets(4'h3, 32'h0000_3000, '{1'b0, 1'b0, 1'b0, MODE_USER});
        @(negedge clk);
        irqReq = 1'b1;
        irqOffset = 14'h3FFF;
        // base rewritten on the interrupt's own edge: the old base must still be used
        vecBaseWrEn = 1'b1;
        vecBaseWrData = 32'h0000_8000;
        @(negedge clk);
        clearIns();
        chk32("irq ack", 32'h1, 32'(irqAck_r));
        chk32("irq pc", BASE + 32'h0000_3FFF, redirPc_r);
        chk32("base after irq", 32'h0000_8000, vecBase_r);
        chk32("irq mask", 32'h1, 32'(sr_r.globalMask));
        repeat (3) @(negedge clk);
        finishTest();
    end
endmodule
